// ---- rtl/lsgp_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module lsgp_top #(
	parameter int PF_W = 8
) (
	input wire logic i_sys_clk, // system clock
	input wire logic i_rst, // synchronous reset, high
	input wire lsgp_pkg::lsgp_bus_req_s i_bus, // register request
	output logic [7:0] o_rd_data, // read data, cycle after read
	input wire logic [7:4] i_pe_pin, // port E pad levels
	output logic [7:4] o_pe_out, // port E pad output levels
	output logic [7:4] o_pe_oe, // port E pad output enables
	input wire logic [PF_W-1:0] i_pf_pin, // port F pad levels
	output logic [PF_W-1:0] o_pf_out, // port F pad output levels
	output logic [PF_W-1:0] o_pf_oe, // port F pad output enables
	input wire logic i_ccp_two_pin_select, // zero puts channel two on pin 7
	input wire logic i_capture_compare_pwm_two_drive, // channel two compare or PWM active
	input wire logic i_capture_compare_pwm_two_level, // channel two output level
	output logic o_capture_compare_pwm_two_capture // pin 7 level to channel two capture
);
	import lsgp_pkg::*;

	generate
		if (PF_W != 8) begin : g_bad_width
			$error("lsgp_top: port F segment map serves exactly eight pins");
		end
	endgenerate

	lsgp_top_s st;
	lsgp_top_s next_st;

	logic [7:4] pe_sync;
	logic [PF_W-1:0] pf_sync;
	logic [7:4] pe_avail;
	logic [7:4] pe_alt_en;
	logic [7:4] pe_out_c;
	logic [7:4] pe_oe_c;
	logic [PF_W-1:0] pf_avail;
	logic [PF_W-1:0] pf_out_c;
	logic [PF_W-1:0] pf_oe_c;
	logic ccp_on;
	logic [7:0] rd_val;

	lsgp_sync #(
		.W(4)
	) u_pe_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_d(i_pe_pin),
		.o_q(pe_sync)
	);

	lsgp_sync #(
		.W(PF_W)
	) u_pf_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_d(i_pf_pin),
		.o_q(pf_sync)
	);

	assign ccp_on = ~i_ccp_two_pin_select;

	// Each active common beyond the first takes one more pad, starting from pin 4.
	always_comb begin
		case (lsgp_lcd_count_e'(st.lcd_ctl[LCD_COUNT_LSB+:2]))
			LSGP_COM_ONE: pe_avail[6:4] = 3'b111;
			LSGP_COM_TWO: pe_avail[6:4] = 3'b110;
			LSGP_COM_THREE: pe_avail[6:4] = 3'b100;
			default: pe_avail[6:4] = 3'b000;
		endcase
		pe_avail[7] = ~st.lcd_se3[SE3_SEGMENT_DRIVE_31_BIT];
	end

	// Channel two only overrides while driving an output direction.
	assign pe_alt_en = {ccp_on & i_capture_compare_pwm_two_drive, 3'b000};

	// Port F pads follow segments 18 upward across the two enable registers.
	assign pf_avail = ~{st.lcd_se3[1:0], st.lcd_se2[7:PF_SE2_LSB]};

	generate
		for (genvar i = 4; i < 8; i++) begin : g_pe_cell
			lsgp_pin_cell u_cell (
				.i_avail(pe_avail[i]),
				.i_dir(st.pe_dir[i]),
				.i_lat(st.pe_lat[i]),
				.i_alt_en(pe_alt_en[i]),
				.i_alt_val(i_capture_compare_pwm_two_level),
				.o_out(pe_out_c[i]),
				.o_oe(pe_oe_c[i])
			);
		end
		for (genvar j = 0; j < PF_W; j++) begin : g_pf_cell
			lsgp_pin_cell u_cell (
				.i_avail(pf_avail[j]),
				.i_dir(st.pf_dir[j]),
				.i_lat(st.pf_lat[j]),
				.i_alt_en(1'b0),
				.i_alt_val(1'b0),
				.o_out(pf_out_c[j]),
				.o_oe(pf_oe_c[j])
			);
		end
	endgenerate

	// Pin registers show pad levels, latch registers show the latch,
	// so read-modify-write on a latch never picks up a loaded pad.
	always_comb begin
		rd_val = 8'h00;
		if (i_bus.addr == OFS_PE_PINS) begin
			rd_val = {pe_sync, 4'h0};
		end else if (i_bus.addr == OFS_PE_LAT) begin
			rd_val = {st.pe_lat, 4'h0};
		end else if (i_bus.addr == OFS_PE_DIR) begin
			rd_val = {st.pe_dir, 4'h0};
		end else if (i_bus.addr == OFS_PF_PINS) begin
			rd_val = pf_sync & ~st.adc_cfg;
		end else if (i_bus.addr == OFS_PF_LAT) begin
			rd_val = st.pf_lat;
		end else if (i_bus.addr == OFS_PF_DIR) begin
			rd_val = st.pf_dir;
		end else if (i_bus.addr == OFS_LCD_CTL) begin
			rd_val = st.lcd_ctl;
		end else if (i_bus.addr == OFS_LCD_SE2) begin
			rd_val = st.lcd_se2;
		end else if (i_bus.addr == OFS_LCD_SE3) begin
			rd_val = st.lcd_se3;
		end else if (i_bus.addr == OFS_ADC_CFG) begin
			rd_val = st.adc_cfg;
		end
	end

	always_comb begin
		next_st = st;
		next_st.pe_out = pe_out_c;
		next_st.pe_oe = pe_oe_c;
		next_st.pf_out = pf_out_c;
		next_st.pf_oe = pf_oe_c;
		next_st.cap = ccp_on & st.pe_dir[7] & pe_sync[7];
		next_st.rdata = i_bus.rd ? rd_val : 8'h00;
		if (i_bus.wr) begin
			if (i_bus.addr == OFS_PE_PINS || i_bus.addr == OFS_PE_LAT) begin
				next_st.pe_lat = i_bus.wdata[7:4];
			end else if (i_bus.addr == OFS_PE_DIR) begin
				next_st.pe_dir = i_bus.wdata[7:4];
			end else if (i_bus.addr == OFS_PF_PINS || i_bus.addr == OFS_PF_LAT) begin
				next_st.pf_lat = i_bus.wdata;
			end else if (i_bus.addr == OFS_PF_DIR) begin
				next_st.pf_dir = i_bus.wdata;
			end else if (i_bus.addr == OFS_LCD_CTL) begin
				next_st.lcd_ctl = i_bus.wdata & LCD_CTL_MASK;
			end else if (i_bus.addr == OFS_LCD_SE2) begin
				next_st.lcd_se2 = i_bus.wdata;
			end else if (i_bus.addr == OFS_LCD_SE3) begin
				next_st.lcd_se3 = i_bus.wdata;
			end else if (i_bus.addr == OFS_ADC_CFG) begin
				// Analog pads must be released here before digital pin reads.
				next_st.adc_cfg = i_bus.wdata;
			end
		end
		if (i_rst) begin
			next_st = LSGP_TOP_RST;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		st <= next_st;
	end

	assign o_rd_data = st.rdata;
	assign o_pe_out = st.pe_out;
	assign o_pe_oe = st.pe_oe;
	assign o_pf_out = st.pf_out;
	assign o_pf_oe = st.pf_oe;
	assign o_capture_compare_pwm_two_capture = st.cap;

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);

	property p_pe_input_hiz;
		!$past(i_rst) |-> ((o_pe_oe & $past(st.pe_dir)) == 4'h0);
	endproperty
	a_pe_input_hiz: assert property (p_pe_input_hiz)
		else $error("port E pad driven while direction is input");

	property p_pe4_drives_latch;
		(!st.pe_dir[4] && st.lcd_ctl[1:0] == 2'b00)
			|=> (o_pe_oe[4] && o_pe_out[4] == $past(st.pe_lat[4]));
	endproperty
	a_pe4_drives_latch: assert property (p_pe4_drives_latch)
		else $error("port E pin 4 not driving its latch value");

	property p_pf_latch_readback;
		(i_bus.wr && i_bus.addr == OFS_PF_LAT)
			##1 (i_bus.rd && i_bus.addr == OFS_PF_LAT && !i_bus.wr)
			|=> (o_rd_data == $past(i_bus.wdata, 2));
	endproperty
	a_pf_latch_readback: assert property (p_pf_latch_readback)
		else $error("port F latch read back differs from value written");

	property p_pe_latch_readback;
		(i_bus.wr && i_bus.addr == OFS_PE_LAT)
			##1 (i_bus.rd && i_bus.addr == OFS_PE_LAT && !i_bus.wr)
			|=> (o_rd_data == {$past(i_bus.wdata[7:4], 2), 4'h0});
	endproperty
	a_pe_latch_readback: assert property (p_pe_latch_readback)
		else $error("port E latch read back differs from value written");

	property p_reset_inputs;
		$past(i_rst) |-> (st.pe_dir == RST_PE_DIR && st.pf_dir == RST_PF_DIR
			&& o_pe_oe == 4'h0);
	endproperty
	a_reset_inputs: assert property (p_reset_inputs)
		else $error("pins not inputs after reset");

	property p_all_commons;
		(st.lcd_ctl[1:0] == 2'b11) |=> (o_pe_oe[6:4] == 3'b000);
	endproperty
	a_all_commons: assert property (p_all_commons)
		else $error("port E pins 6..4 driven with four commons active");

	property p_two_commons;
		(st.lcd_ctl[1:0] == 2'b01 && st.pe_dir[5:4] == 2'b00)
			|=> (!o_pe_oe[4] && o_pe_oe[5]);
	endproperty
	a_two_commons: assert property (p_two_commons)
		else $error("wrong pad released with two commons active");

	property p_segment_drive_31_owns_pin7;
		st.lcd_se3[SE3_SEGMENT_DRIVE_31_BIT] |=> !o_pe_oe[7];
	endproperty
	a_segment_drive_31_owns_pin7: assert property (p_segment_drive_31_owns_pin7)
		else $error("pin 7 driven while segment 31 enabled");

	property p_ccp_override;
		(!i_ccp_two_pin_select && i_capture_compare_pwm_two_drive && !st.pe_dir[7]
			&& !st.lcd_se3[SE3_SEGMENT_DRIVE_31_BIT])
			|=> (o_pe_oe[7] && o_pe_out[7] == $past(i_capture_compare_pwm_two_level));
	endproperty
	a_ccp_override: assert property (p_ccp_override)
		else $error("channel two output did not take pin 7");

	property p_ccp_capture;
		(i_ccp_two_pin_select == 1'b0 && st.pe_dir[7])
			|=> (o_capture_compare_pwm_two_capture == $past(pe_sync[7]));
	endproperty
	a_ccp_capture: assert property (p_ccp_capture)
		else $error("pin 7 level not passed to channel two capture");

	property p_pe_low_nibble;
		(i_bus.rd && (i_bus.addr == OFS_PE_PINS || i_bus.addr == OFS_PE_LAT
			|| i_bus.addr == OFS_PE_DIR)) |=> (o_rd_data[3:0] == 4'h0);
	endproperty
	a_pe_low_nibble: assert property (p_pe_low_nibble)
		else $error("port E low nibble not read as zero");

	property p_pf_input_hiz;
		!$past(i_rst) |-> ((o_pf_oe & $past(st.pf_dir)) == 8'h00);
	endproperty
	a_pf_input_hiz: assert property (p_pf_input_hiz)
		else $error("port F pad driven while direction is input");

	property p_pf_analog_zero;
		(i_bus.rd && i_bus.addr == OFS_PF_PINS)
			|=> ((o_rd_data & $past(st.adc_cfg)) == 8'h00);
	endproperty
	a_pf_analog_zero: assert property (p_pf_analog_zero)
		else $error("analog port F pin read as nonzero");

	property p_pf_segment;
		st.lcd_se2[PF_SE2_LSB] |=> !o_pf_oe[0];
	endproperty
	a_pf_segment: assert property (p_pf_segment)
		else $error("port F pin 0 driven while its segment enabled");

	property p_port_write_latch;
		(i_bus.wr && i_bus.addr == OFS_PE_PINS)
			|=> (st.pe_lat == $past(i_bus.wdata[7:4]));
	endproperty
	a_port_write_latch: assert property (p_port_write_latch)
		else $error("port E pin write did not load the latch");

	property p_port_read_pins;
		(i_bus.rd && i_bus.addr == OFS_PE_PINS)
			|=> (o_rd_data[7:4] == $past(pe_sync));
	endproperty
	a_port_read_pins: assert property (p_port_read_pins)
		else $error("port E pin read did not return pad levels");

	property p_rdata_one_cycle;
		!i_bus.rd |=> (o_rd_data == 8'h00);
	endproperty
	a_rdata_one_cycle: assert property (p_rdata_one_cycle)
		else $error("read data present without a read");

	property p_one_common;
		(st.lcd_ctl[1:0] == 2'b00 && st.pe_dir[6:4] == 3'b000) |=> (o_pe_oe[6:4] == 3'b111);
	endproperty
	a_one_common: assert property (p_one_common)
		else $error("port E pins 6..4 not driven with one common active");

	property p_three_commons;
		(st.lcd_ctl[1:0] == 2'b10 && !st.pe_dir[6]) |=> (o_pe_oe[6:4] == 3'b100);
	endproperty
	a_three_commons: assert property (p_three_commons)
		else $error("wrong port E pads driven with three commons active");

	property p_capture_off;
		i_ccp_two_pin_select |=> !o_capture_compare_pwm_two_capture;
	endproperty
	a_capture_off: assert property (p_capture_off)
		else $error("capture fed while channel two is on its default pin");

	property p_pin7_latch;
		(!st.pe_dir[7] && !st.lcd_se3[SE3_SEGMENT_DRIVE_31_BIT]
			&& (i_ccp_two_pin_select || !i_capture_compare_pwm_two_drive))
			|=> (o_pe_oe[7] && o_pe_out[7] == $past(st.pe_lat[7]));
	endproperty
	a_pin7_latch: assert property (p_pin7_latch)
		else $error("port E pin 7 not driving its latch value");

	property p_pf_drives_latch;
		(st.pf_dir == 8'h00 && st.lcd_se2[7:PF_SE2_LSB] == 6'h00
			&& st.lcd_se3[1:0] == 2'b00)
			|=> (o_pf_oe == 8'hFF && o_pf_out == $past(st.pf_lat));
	endproperty
	a_pf_drives_latch: assert property (p_pf_drives_latch)
		else $error("port F pads not driving the latch value");

	// Bit 4 of the control register has no storage, so it must never read back as one.
	property p_ctl_bit4_zero;
		(i_bus.rd && i_bus.addr == OFS_LCD_CTL) |=> !o_rd_data[4];
	endproperty
	a_ctl_bit4_zero: assert property (p_ctl_bit4_zero)
		else $error("unimplemented control bit read as one");

	c_pin7_ccp_out: cover property (
		!i_ccp_two_pin_select && i_capture_compare_pwm_two_drive && !st.pe_dir[7] ##1 o_pe_oe[7]);
	c_lcd_three_com: cover property (
		st.lcd_ctl[1:0] == 2'b10 && !st.pe_dir[6] ##1 o_pe_oe[6]);
	c_pf_all_out: cover property (st.pf_dir == 8'h00 ##1 o_pf_oe == 8'hFF);
	c_pe_rmw: cover property (
		(i_bus.rd && i_bus.addr == OFS_PE_LAT) ##1 (i_bus.wr && i_bus.addr == OFS_PE_LAT));
	c_pin7_capture: cover property (
		!i_ccp_two_pin_select && st.pe_dir[7] ##1 o_capture_compare_pwm_two_capture);
endmodule // lsgp_top
`default_nettype wire

// ---- rtl/lsgp_pkg.sv ----
// Overview of operation
// - Port E uses pins 7..4 only.
// - Direction one puts the pin in high impedance.
// - Direction zero drives the latch value.
// - Port E latch readable; read returns latch.
// - Reset makes all port E pins inputs.
// - Common count selects port E pins 6..4.
// - Active common drive disables digital output.
// - Segment 31 enable removes pin 7 function.
// - Pin select zero routes channel two pin.
// - Channel two output overrides latch; input captures.
// - Port E bits 3..0 read zero.
// - Port F has eight pins, same direction convention.
// - Port F latch readable; read returns latch.
// - Reset leaves port F pins 6..0 reading zero.
// - Enabled segment removes port F pin function.
package lsgp_pkg;

	localparam int LSGP_ADDR_W = 4;

	// Register word addresses on the software port.
	localparam logic [3:0] OFS_PE_PINS = 4'h0;
	localparam logic [3:0] OFS_PE_LAT = 4'h1;
	localparam logic [3:0] OFS_PE_DIR = 4'h2;
	localparam logic [3:0] OFS_PF_PINS = 4'h3;
	localparam logic [3:0] OFS_PF_LAT = 4'h4;
	localparam logic [3:0] OFS_PF_DIR = 4'h5;
	localparam logic [3:0] OFS_LCD_CTL = 4'h6;
	localparam logic [3:0] OFS_LCD_SE2 = 4'h7;
	localparam logic [3:0] OFS_LCD_SE3 = 4'h8;
	localparam logic [3:0] OFS_ADC_CFG = 4'h9;

	// Field positions.
	localparam int LCD_COUNT_LSB = 0;
	localparam int SE3_SEGMENT_DRIVE_31_BIT = 7;
	localparam int PF_SE2_LSB = 2;
	localparam logic [7:0] LCD_CTL_MASK = 8'hEF;

	// Reset values.
	localparam logic [7:4] RST_PE_DIR = 4'hF;
	localparam logic [7:4] RST_PE_LAT = 4'h0;
	localparam logic [7:0] RST_PF_DIR = 8'hFF;
	localparam logic [7:0] RST_PF_LAT = 8'h00;
	localparam logic [7:0] RST_LCD_CTL = 8'h00;
	localparam logic [7:0] RST_LCD_SE = 8'h00;
	localparam logic [7:0] RST_ADC_CFG = 8'h7F;

	typedef enum logic [1:0] {
		LSGP_COM_ONE = 2'b00,
		LSGP_COM_TWO = 2'b01,
		LSGP_COM_THREE = 2'b10,
		LSGP_COM_FOUR = 2'b11
	} lsgp_lcd_count_e;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} lsgp_bus_req_s;

	typedef struct packed {
		logic [7:4] pe_lat;
		logic [7:4] pe_dir;
		logic [7:0] pf_lat;
		logic [7:0] pf_dir;
		logic [7:0] lcd_ctl;
		logic [7:0] lcd_se2;
		logic [7:0] lcd_se3;
		logic [7:0] adc_cfg;
		logic [7:0] rdata;
		logic [7:4] pe_out;
		logic [7:4] pe_oe;
		logic [7:0] pf_out;
		logic [7:0] pf_oe;
		logic cap;
	} lsgp_top_s;

	localparam lsgp_top_s LSGP_TOP_RST = '{
		pe_lat: RST_PE_LAT,
		pe_dir: RST_PE_DIR,
		pf_lat: RST_PF_LAT,
		pf_dir: RST_PF_DIR,
		lcd_ctl: RST_LCD_CTL,
		lcd_se2: RST_LCD_SE,
		lcd_se3: RST_LCD_SE,
		adc_cfg: RST_ADC_CFG,
		rdata: 8'h00,
		pe_out: 4'h0,
		pe_oe: 4'h0,
		pf_out: 8'h00,
		pf_oe: 8'h00,
		cap: 1'b0
	};

endpackage

// ---- rtl/lsgp_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module lsgp_sync #(
	parameter int W = 1
) (
	input wire logic i_sys_clk, // system clock
	input wire logic i_rst, // synchronous reset
	input wire logic [W-1:0] i_d, // raw pin levels
	output logic [W-1:0] o_q // synchronized levels
);
	generate
		if (W < 1) begin : g_bad_width
			$error("lsgp_sync: width must be at least one");
		end
	endgenerate

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} lsgp_sync_s;

	lsgp_sync_s st;
	lsgp_sync_s next_st;

	// The first stage feeds only the second; nothing else looks at it.
	always_comb begin
		next_st.meta = i_d;
		next_st.q = st.meta;
		if (i_rst) begin
			next_st = '0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		st <= next_st;
	end

	assign o_q = st.q;
endmodule // lsgp_sync
`default_nettype wire

// ---- rtl/lsgp_pin_cell.sv ----
`timescale 1ns/10ps
`default_nettype none
module lsgp_pin_cell (
	input wire logic i_avail, // port function owns the pad
	input wire logic i_dir, // one means input
	input wire logic i_lat, // latched output value
	input wire logic i_alt_en, // peripheral output overrides latch
	input wire logic i_alt_val, // peripheral output level
	output logic o_out, // pad output level
	output logic o_oe // pad output enable, high drives
);
	// An LCD owned pad keeps its digital driver off whatever the direction.
	assign o_oe = i_avail & ~i_dir;
	// The out level is parked low while undriven so the pad sees no toggling.
	assign o_out = o_oe & (i_alt_en ? i_alt_val : i_lat);
endmodule // lsgp_pin_cell
`default_nettype wire

// ---- dv/lsgp_pad_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module lsgp_pad_model #(
	parameter int W = 8
) (
	input wire logic i_sys_clk, // system clock
	input wire logic [W-1:0] i_out, // block output levels
	input wire logic [W-1:0] i_oe, // block output enables
	input wire logic [W-1:0] i_ext, // external driver levels
	input wire logic [W-1:0] i_ext_en, // external driver enables
	output logic [W-1:0] o_pad // resolved pad levels
);
	// A floating pad toggles every cycle so a stale value can never look correct.
	logic [W-1:0] float_lvl = '0;
	always @(posedge i_sys_clk) begin
		float_lvl <= ~float_lvl;
	end
	always_comb begin
		for (int j = 0; j < W; j++) begin
			if (i_oe[j]) begin
				o_pad[j] = i_out[j];
			end else if (i_ext_en[j]) begin
				o_pad[j] = i_ext[j];
			end else begin
				o_pad[j] = float_lvl[j];
			end
		end
	end
endmodule // lsgp_pad_model
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import lsgp_pkg::*;
	logic i_sys_clk = 1'b0;
	logic i_rst = 1'b1;
	lsgp_bus_req_s i_bus = '0;
	logic [7:0] o_rd_data;
	logic [7:4] pe_pin, o_pe_out, o_pe_oe;
	logic [7:4] pe_ext = '0;
	logic [7:4] pe_ext_en = '0;
	logic [7:0] pf_pin, o_pf_out, o_pf_oe;
	logic [7:0] pf_ext = '0;
	logic [7:0] pf_ext_en = '0;
	logic ccp_sel = 1'b1;
	logic ccp_drive = 1'b0;
	logic ccp_level = 1'b0;
	logic o_capture_compare_pwm_two_capture;
	int miscompares = 0;
	int check_count = 0;
	int cycles = 0;
	logic rd_seen = 1'b0;
	logic [7:0] exp_q[$];
	logic [7:0] v, d, se2, se3;
	logic [3:0] eo;

	always #2 i_sys_clk = ~i_sys_clk;

	lsgp_top #(.PF_W(8)) u_lsgp_top (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_bus(i_bus),
		.o_rd_data(o_rd_data), .i_pe_pin(pe_pin), .o_pe_out(o_pe_out), .o_pe_oe(o_pe_oe),
		.i_pf_pin(pf_pin), .o_pf_out(o_pf_out), .o_pf_oe(o_pf_oe),
		.i_ccp_two_pin_select(ccp_sel), .i_capture_compare_pwm_two_drive(ccp_drive), .i_capture_compare_pwm_two_level(ccp_level),
		.o_capture_compare_pwm_two_capture(o_capture_compare_pwm_two_capture));
	lsgp_pad_model #(.W(4)) u_pad_e (.i_sys_clk(i_sys_clk), .i_out(o_pe_out), .i_oe(o_pe_oe),
		.i_ext(pe_ext), .i_ext_en(pe_ext_en), .o_pad(pe_pin));
	lsgp_pad_model #(.W(8)) u_pad_f (.i_sys_clk(i_sys_clk), .i_out(o_pf_out), .i_oe(o_pf_oe),
		.i_ext(pf_ext), .i_ext_en(pf_ext_en), .o_pad(pf_pin));

	task automatic summarize();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] addr, input logic [7:0] data);
		@(posedge i_sys_clk);
		i_bus <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
		@(posedge i_sys_clk);
		i_bus <= '0;
	endtask

	task automatic rd(input logic [3:0] addr, input logic [7:0] exp);
		@(posedge i_sys_clk);
		i_bus <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		exp_q.push_back(exp);
		@(posedge i_sys_clk);
		i_bus <= '0;
	endtask

	// Two requests on consecutive cycles, so write-then-read and read-then-write meet.
	task automatic two(input lsgp_bus_req_s a, input lsgp_bus_req_s b, input logic [7:0] exp);
		@(posedge i_sys_clk);
		i_bus <= a;
		if (a.rd) begin
			exp_q.push_back(exp);
		end
		@(posedge i_sys_clk);
		i_bus <= b;
		if (b.rd) begin
			exp_q.push_back(exp);
		end
		@(posedge i_sys_clk);
		i_bus <= '0;
	endtask

	// Pad outputs trail a register write by two edges, so three edges leave margin.
	task automatic pads(input logic [3:0] e_oe, input logic [3:0] e_out,
		input logic [7:0] f_oe, input logic [7:0] f_out);
		repeat (3) @(posedge i_sys_clk);
		#1;
		check("pe_oe", {4'h0, o_pe_oe}, {4'h0, e_oe});
		check("pe_out", {4'h0, o_pe_out}, {4'h0, e_out});
		check("pf_oe", o_pf_oe, f_oe);
		check("pf_out", o_pf_out, f_out);
	endtask

	always @(posedge i_sys_clk) begin
		cycles <= cycles + 1;
		rd_seen <= i_bus.rd;
		if (rd_seen) begin
			check("rd_data", o_rd_data, exp_q.pop_front());
		end
		if (cycles == 5000) begin
			miscompares++;
			summarize();
		end
	end

	initial begin
		void'($urandom(32'h6510));
		repeat (10) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		rd(OFS_PE_DIR, 8'hF0);
		rd(OFS_PE_LAT, 8'h00);
		rd(OFS_PF_DIR, 8'hFF);
		rd(OFS_PF_LAT, 8'h00);
		rd(OFS_LCD_CTL, 8'h00);
		rd(OFS_ADC_CFG, 8'h7F);
		rd(4'hF, 8'h00);
		pads(4'h0, 4'h0, 8'h00, 8'h00);
		pf_ext <= 8'hFF;
		pf_ext_en <= 8'hFF;
		pe_ext <= 4'hA;
		pe_ext_en <= 4'hF;
		repeat (4) @(posedge i_sys_clk);
		rd(OFS_PF_PINS, 8'h80);
		rd(OFS_PE_PINS, 8'hA0);
		pe_ext_en <= 4'h0;
		pf_ext_en <= 8'h00;
		v = 8'($urandom);
		wr(OFS_PE_PINS, v);
		rd(OFS_PE_LAT, v & 8'hF0);
		wr(OFS_PF_PINS, ~v);
		rd(OFS_PF_LAT, ~v);
		two('{addr: OFS_PE_LAT, wdata: 8'h00, wr: 1'b0, rd: 1'b1},
			'{addr: OFS_PE_LAT, wdata: ~v, wr: 1'b1, rd: 1'b0}, v & 8'hF0);
		two('{addr: OFS_PF_LAT, wdata: v, wr: 1'b1, rd: 1'b0},
			'{addr: OFS_PF_LAT, wdata: 8'h00, wr: 1'b0, rd: 1'b1}, v);
		two('{addr: OFS_PE_LAT, wdata: v, wr: 1'b1, rd: 1'b0},
			'{addr: OFS_PE_LAT, wdata: 8'h00, wr: 1'b0, rd: 1'b1}, v & 8'hF0);
		for (int c = 0; c < 4; c++) begin
			d = 8'($urandom);
			v = 8'($urandom);
			// Port pins among 6..4 become outputs below four commons, except pin 6 with two commons, so every count shows its driven pads.
			if (c < 3) begin
				d[6:4] = d[6:4] & {c == 1, 2'b00};
			end
			wr(OFS_LCD_CTL, {v[7:2], 2'(c)});
			rd(OFS_LCD_CTL, {v[7:5], 1'b0, v[3:2], 2'(c)});
			wr(OFS_PE_DIR, d);
			wr(OFS_PE_LAT, v);
			eo = ~d[7:4] & {1'b1, 3'b111 << c};
			pads(eo, v[7:4] & eo, 8'h00, 8'h00);
		end
		wr(OFS_PE_DIR, 8'h00);
		wr(OFS_PE_LAT, 8'h80);
		wr(OFS_LCD_SE3, 8'h80);
		pads(4'h0, 4'h0, 8'h00, 8'h00);
		wr(OFS_LCD_SE3, 8'h00);
		wr(OFS_PE_LAT, 8'h00);
		ccp_sel <= 1'b0;
		ccp_drive <= 1'b1;
		ccp_level <= 1'b1;
		pads(4'h8, 4'h8, 8'h00, 8'h00);
		wr(OFS_PE_DIR, 8'h80);
		pe_ext <= 4'h8;
		pe_ext_en <= 4'h8;
		repeat (5) @(posedge i_sys_clk);
		#1;
		check("capture", {7'h00, o_capture_compare_pwm_two_capture}, 8'h01);
		pe_ext <= 4'h0;
		repeat (5) @(posedge i_sys_clk);
		#1;
		check("capture", {7'h00, o_capture_compare_pwm_two_capture}, 8'h00);
		wr(OFS_ADC_CFG, 8'h00);
		wr(OFS_PF_DIR, 8'h00);
		se2 = 8'($urandom);
		se3 = 8'($urandom);
		v = 8'($urandom);
		wr(OFS_LCD_SE2, se2);
		wr(OFS_LCD_SE3, se3);
		wr(OFS_PF_LAT, v);
		pads(4'h0, 4'h0, ~{se3[1:0], se2[7:2]}, v & ~{se3[1:0], se2[7:2]});
		wr(OFS_PF_DIR, 8'hFF);
		v = 8'($urandom);
		pf_ext <= v;
		pf_ext_en <= 8'hFF;
		repeat (4) @(posedge i_sys_clk);
		rd(OFS_PF_PINS, v);
		repeat (3) @(posedge i_sys_clk);
		summarize();
	end
endmodule // tb_top
`default_nettype wire
